// ### hdl/sdss_top.v
`timescale 1ns/1ps
`default_nettype none
`include "sdss_consts.vh"
module sdss_top #(
  parameter [31:0] FLICK_CYC = `SDSS_FLICK_CYC,
  parameter [31:0] FAULT_CYC = `SDSS_FAULT_CYC
) (
  input  wire       CLK_SYS_I,
  input  wire       NRST_I,
  input  wire       POWER_ON_I,
  input  wire       ABS_MODE_I,
  input  wire       ABS_VALID_I,
  input  wire       TEST_MODE_I,
  input  wire [3:0] ROTARY_AXIS_SELECTOR_I,
  input  wire [3:0] INIT_PHASE_I,
  input  wire       COMM_FAULT_I,
  input  wire       CTRL_SERVO_ON_I,
  input  wire       CTRL_SERVO_OFF_I,
  input  wire       CTRL_ESTOP_I,
  input  wire       EXTERNAL_FORCED_STOP_INPUT_N_I,
  input  wire       ALARM_I,
  input  wire [7:0] ALARM_NUM_I,
  input  wire       WARN_I,
  input  wire [7:0] WARN_NUM_I,
  input  wire       PARAM_WE_I,
  input  wire [3:0] ROTATION_DIRECTION_PARAM_I,
  input  wire [3:0] AUTO_TUNING_MODE_PARAM_I,
  input  wire [7:0] AUTO_TUNING_RESPONSE_PARAM_I,
  input  wire       ADDR_UP_I,
  input  wire       ADDR_DN_I,
  output wire       MOTOR_CCW_O,
  output wire       MOTOR_CW_O,
  output wire       AUTO_TUNE_EN_O,
  output wire [7:0] AUTO_TUNE_RESP_O,
  output reg        SERVO_ON_O,
  output reg        ABS_LOST_ALARM_O,
  output wire       BASE_ON_O,
  output wire       DYN_BRAKE_O,
  output wire       CTRL_ES_WARN_O,
  output wire       LOCAL_ES_WARN_O,
  output wire [7:0] SEG0_O,
  output wire [7:0] SEG1_O,
  output wire [7:0] SEG2_O
);
  // two-stage synchronisers for pin inputs
  reg [3:0] axis_s1_q;
  reg [3:0] axis_s2_q;
  reg       estop_s1_q;
  reg       estop_s2_q;
  reg       test_s1_q;
  reg       test_s2_q;
  // parameter staging and active copies
  reg [3:0] dir_pend_q;
  reg [3:0] atm_pend_q;
  reg [7:0] atr_pend_q;
  reg [3:0] dir_act_q;
  reg [3:0] atm_act_q;
  reg [7:0] atr_act_q;
  reg       pwr_q;
  reg       abs_seen_q;
  reg [31:0] flick_cnt_q;
  reg        flick_q;
  reg [31:0] fault_cnt_q;
  reg [1:0]  fault_step_q;
  reg [3:0]  phase;
  reg [4:0]  gl0;
  reg [4:0]  gl1;
  reg [4:0]  gl2;
  reg [2:0]  dp;
  reg        ccw_q;
  reg        cw_q;
  reg        aten_q;
  wire       pwr_rise;
  wire       any_alarm;
  wire       servo_req;
  wire [4:0] axis_num;
  wire [4:0] axis_tens;
  wire [4:0] axis_ones;

  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      axis_s1_q  <= 4'h0;
      axis_s2_q  <= 4'h0;
      estop_s1_q <= 1'b1; // pin idles high, no false stop
      estop_s2_q <= 1'b1;
      test_s1_q  <= 1'b0;
      test_s2_q  <= 1'b0;
    end else begin
      axis_s1_q  <= ROTARY_AXIS_SELECTOR_I;
      axis_s2_q  <= axis_s1_q;
      estop_s1_q <= EXTERNAL_FORCED_STOP_INPUT_N_I;
      estop_s2_q <= estop_s1_q;
      test_s1_q  <= TEST_MODE_I;
      test_s2_q  <= test_s1_q;
    end
  end

  assign pwr_rise = POWER_ON_I & ~pwr_q;

  // parameters staged; copied to active only on power-up
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pwr_q      <= 1'b0;
      dir_pend_q <= `SDSS_RST_DIR;
      atm_pend_q <= `SDSS_RST_ATMODE;
      atr_pend_q <= `SDSS_RST_ATRESP;
      dir_act_q  <= `SDSS_RST_DIR;
      atm_act_q  <= `SDSS_RST_ATMODE;
      atr_act_q  <= `SDSS_RST_ATRESP;
    end else begin
      pwr_q <= POWER_ON_I;
      if (PARAM_WE_I) begin
        dir_pend_q <= ROTATION_DIRECTION_PARAM_I;
        atm_pend_q <= AUTO_TUNING_MODE_PARAM_I;
        atr_pend_q <= AUTO_TUNING_RESPONSE_PARAM_I;
      end
      if (pwr_rise) begin
        dir_act_q <= dir_pend_q;
        atm_act_q <= atm_pend_q;
        atr_act_q <= atr_pend_q;
      end
    end
  end

  // direction and tuning registered from active parameters
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ccw_q  <= 1'b0;
      cw_q   <= 1'b0;
      aten_q <= (`SDSS_RST_ATMODE == 4'h1);
    end else begin
      ccw_q  <= (dir_act_q == 4'h0) ? ADDR_UP_I : ADDR_DN_I;
      cw_q   <= (dir_act_q == 4'h0) ? ADDR_DN_I : ADDR_UP_I;
      aten_q <= (atm_act_q == 4'h1);
    end
  end

  // outputs straight from flip-flops
  assign MOTOR_CCW_O      = ccw_q;
  assign MOTOR_CW_O       = cw_q;
  assign AUTO_TUNE_EN_O   = aten_q;
  assign AUTO_TUNE_RESP_O = atr_act_q;

  // absolute position lost alarm, cleared at next power-up
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      abs_seen_q       <= 1'b0;
      ABS_LOST_ALARM_O <= 1'b0;
    end else if (pwr_rise) begin
      ABS_LOST_ALARM_O <= ABS_MODE_I & ~abs_seen_q & ~ABS_VALID_I;
      abs_seen_q       <= 1'b1;
    end
  end

  assign any_alarm = ALARM_I | ABS_LOST_ALARM_O;
  assign servo_req = CTRL_SERVO_ON_I & ~CTRL_SERVO_OFF_I & POWER_ON_I;

  // servo state, refused under alarm
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      SERVO_ON_O <= 1'b0;
    end else begin
      SERVO_ON_O <= servo_req & ~any_alarm & ~CTRL_ESTOP_I & estop_s2_q;
    end
  end

  sdss_stop_ctl u_stop (
    .clk_i           (CLK_SYS_I),
    .nrst_i          (NRST_I),
    .servo_on_i      (SERVO_ON_O),
    .servo_off_cmd_i (CTRL_SERVO_OFF_I),
    .ctrl_estop_i    (CTRL_ESTOP_I),
    .alarm_i         (any_alarm),
    .ext_estop_n_i   (estop_s2_q),
    .base_on_o       (BASE_ON_O),
    .dyn_brake_o     (DYN_BRAKE_O),
    .ctrl_es_wrn_o   (CTRL_ES_WARN_O),
    .local_es_wrn_o  (LOCAL_ES_WARN_O)
  );

  // flicker and fault-cycle timers
  always @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      flick_cnt_q  <= 32'h0;
      flick_q      <= 1'b0;
      fault_cnt_q  <= 32'h0;
      fault_step_q <= 2'h0;
    end else begin
      if (flick_cnt_q >= FLICK_CYC - 32'h1) begin
        flick_cnt_q <= 32'h0;
        flick_q     <= ~flick_q;
      end else begin
        flick_cnt_q <= flick_cnt_q + 32'h1;
      end
      if (!COMM_FAULT_I) begin
        fault_cnt_q  <= 32'h0;
        fault_step_q <= 2'h0;
      end else if (fault_cnt_q >= FAULT_CYC - 32'h1) begin
        fault_cnt_q  <= 32'h0;
        fault_step_q <= (fault_step_q == 2'h2) ? 2'h0 : fault_step_q + 2'h1;
      end else begin
        fault_cnt_q <= fault_cnt_q + 32'h1;
      end
    end
  end

  // upper hex digit of a number byte as glyph code
  function [4:0] sdss_dig_hi;
    input [7:0] v;
    begin
      sdss_dig_hi = {1'b0, v[7:4]};
    end
  endfunction

  // lower hex digit of a number byte as glyph code
  function [4:0] sdss_dig_lo;
    input [7:0] v;
    begin
      sdss_dig_lo = {1'b0, v[3:0]};
    end
  endfunction

  // axis field, 00 in test mode else switch plus one
  assign axis_num  = test_s2_q ? 5'h00 : {1'b0, axis_s2_q} + 5'h01;
  assign axis_tens = (axis_num >= 5'd10) ? 5'h01 : 5'h00;
  assign axis_ones = (axis_num >= 5'd10) ? axis_num - 5'd10 : axis_num;

  // indication selection and glyph composition
  always @* begin
    phase = INIT_PHASE_I;
    gl0   = `SDSS_GL_BLANK;
    gl1   = `SDSS_GL_BLANK;
    gl2   = `SDSS_GL_BLANK;
    dp    = 3'b000;
    if (COMM_FAULT_I)
      phase = `SDSS_PH_FAULT;
    if (any_alarm || WARN_I || CTRL_ES_WARN_O || LOCAL_ES_WARN_O) begin
      // number only, no axis
      if (any_alarm) begin
        gl1 = sdss_dig_hi(ABS_LOST_ALARM_O ? `SDSS_ALM_ABS_LOST : ALARM_NUM_I);
        gl2 = sdss_dig_lo(ABS_LOST_ALARM_O ? `SDSS_ALM_ABS_LOST : ALARM_NUM_I);
      end else if (CTRL_ES_WARN_O) begin
        gl1 = sdss_dig_hi(`SDSS_WRN_CTRL_ES);
        gl2 = sdss_dig_lo(`SDSS_WRN_CTRL_ES);
      end else if (LOCAL_ES_WARN_O) begin
        gl1 = sdss_dig_hi(`SDSS_WRN_LOCAL_ES);
        gl2 = sdss_dig_lo(`SDSS_WRN_LOCAL_ES);
      end else begin
        gl1 = sdss_dig_hi(WARN_NUM_I);
        gl2 = sdss_dig_lo(WARN_NUM_I);
        dp[1] = SERVO_ON_O & flick_q;
      end
    end else begin
      case (phase)
        `SDSS_PH_WAIT:     begin gl0 = `SDSS_GL_A; gl1 = `SDSS_GL_B; end
        `SDSS_PH_COMSET:   begin gl0 = `SDSS_GL_A; gl1 = `SDSS_GL_B; dp[1] = 1'b1; end
        `SDSS_PH_SYNC:     begin gl0 = `SDSS_GL_A; gl1 = `SDSS_GL_C; end
        `SDSS_PH_PARAM:    begin gl0 = `SDSS_GL_A; gl1 = `SDSS_GL_D; end
        `SDSS_PH_MOTENC:   begin gl0 = `SDSS_GL_A; gl1 = `SDSS_GL_E; end
        `SDSS_PH_SIGNAL:   begin gl0 = `SDSS_GL_A; gl1 = `SDSS_GL_F; end
        `SDSS_PH_COMPLETE: begin gl0 = `SDSS_GL_A; gl1 = `SDSS_GL_H; end
        `SDSS_PH_STANDBY:  begin gl0 = `SDSS_GL_A; gl1 = `SDSS_GL_A; end
        `SDSS_PH_FAULT: begin
          gl0 = `SDSS_GL_A;
          gl1 = (fault_step_q == 2'h0) ? `SDSS_GL_B :
                (fault_step_q == 2'h1) ? `SDSS_GL_C : `SDSS_GL_D;
        end
        `SDSS_PH_RDYOFF, `SDSS_PH_SRVON, `SDSS_PH_SRVOFF: begin
          gl0 = SERVO_ON_O ? `SDSS_GL_D :
                (phase == `SDSS_PH_SRVOFF) ? `SDSS_GL_C : `SDSS_GL_B;
          gl1 = axis_tens;
          gl2 = axis_ones;
          dp[2] = test_s2_q;
        end
        default: begin gl0 = `SDSS_GL_A; gl1 = `SDSS_GL_B; end
      endcase
    end
  end

  sdss_seg_rom u_rom (
    .clk_i    (CLK_SYS_I),
    .nrst_i   (NRST_I),
    .glyph0_i (gl0),
    .glyph1_i (gl1),
    .glyph2_i (gl2),
    .dp_i     (dp),
    .seg0_o   (SEG0_O),
    .seg1_o   (SEG1_O),
    .seg2_o   (SEG2_O)
  );
endmodule
`default_nettype wire

// ### hdl/sdss_consts.vh
`ifndef SDSS_CONSTS_VH
`define SDSS_CONSTS_VH
// display phase codes
`define SDSS_PH_WAIT      4'h0
`define SDSS_PH_COMSET    4'h1
`define SDSS_PH_SYNC      4'h2
`define SDSS_PH_PARAM     4'h3
`define SDSS_PH_MOTENC    4'h4
`define SDSS_PH_SIGNAL    4'h5
`define SDSS_PH_COMPLETE  4'h6
`define SDSS_PH_STANDBY   4'h7
`define SDSS_PH_RDYOFF    4'h8
`define SDSS_PH_SRVON     4'h9
`define SDSS_PH_SRVOFF    4'ha
`define SDSS_PH_FAULT     4'hb
// glyph codes for the segment lookup
`define SDSS_GL_BLANK     5'h10
`define SDSS_GL_A         5'h0a
`define SDSS_GL_B         5'h0b
`define SDSS_GL_C         5'h0c
`define SDSS_GL_D         5'h0d
`define SDSS_GL_E         5'h0e
`define SDSS_GL_F         5'h0f
`define SDSS_GL_H         5'h11
// alarm and warning numbers
`define SDSS_ALM_ABS_LOST 8'h25
`define SDSS_WRN_LOCAL_ES 8'he6
`define SDSS_WRN_CTRL_ES  8'he7
// reset values of active parameters
`define SDSS_RST_DIR      4'h0
`define SDSS_RST_ATMODE   4'h1
`define SDSS_RST_ATRESP   8'h0c
// field position of the auto tuning enable digit
`define SDSS_ATMODE_LSB   0
// timing in microseconds and derived cycle counts at 40 MHz
`define SDSS_CLK_MHZ      40
`define SDSS_FLICK_US     250000
`define SDSS_FAULT_US     500000
`define SDSS_FLICK_CYC    (`SDSS_FLICK_US * `SDSS_CLK_MHZ)
`define SDSS_FAULT_CYC    (`SDSS_FAULT_US * `SDSS_CLK_MHZ)
`endif

// ### hdl/sdss_seg_rom.v
`timescale 1ns/1ps
`default_nettype none
`include "sdss_consts.vh"
module sdss_seg_rom (
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire [4:0] glyph0_i,
  input  wire [4:0] glyph1_i,
  input  wire [4:0] glyph2_i,
  input  wire [2:0] dp_i,
  output reg  [7:0] seg0_o,
  output reg  [7:0] seg1_o,
  output reg  [7:0] seg2_o
);
  // fixed glyph to segment lookup, bits g..a
  function [6:0] sdss_seg;
    input [4:0] g;
    begin
      case (g)
        5'h00: sdss_seg = 7'h3f;
        5'h01: sdss_seg = 7'h06;
        5'h02: sdss_seg = 7'h5b;
        5'h03: sdss_seg = 7'h4f;
        5'h04: sdss_seg = 7'h66;
        5'h05: sdss_seg = 7'h6d;
        5'h06: sdss_seg = 7'h7d;
        5'h07: sdss_seg = 7'h07;
        5'h08: sdss_seg = 7'h7f;
        5'h09: sdss_seg = 7'h6f;
        5'h0a: sdss_seg = 7'h77;
        5'h0b: sdss_seg = 7'h7c;
        5'h0c: sdss_seg = 7'h39;
        5'h0d: sdss_seg = 7'h5e;
        5'h0e: sdss_seg = 7'h79;
        5'h0f: sdss_seg = 7'h71;
        5'h11: sdss_seg = 7'h76;
        default: sdss_seg = 7'h00;
      endcase
    end
  endfunction

  // registered patterns, decimal point per digit in bit 7
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seg0_o <= 8'h00;
      seg1_o <= 8'h00;
      seg2_o <= 8'h00;
    end else begin
      seg0_o <= {dp_i[0], sdss_seg(glyph0_i)};
      seg1_o <= {dp_i[1], sdss_seg(glyph1_i)};
      seg2_o <= {dp_i[2], sdss_seg(glyph2_i)};
    end
  end
endmodule
`default_nettype wire

// ### hdl/sdss_stop_ctl.v
`timescale 1ns/1ps
`default_nettype none
module sdss_stop_ctl (
  input  wire clk_i,
  input  wire nrst_i,
  input  wire servo_on_i,
  input  wire servo_off_cmd_i,
  input  wire ctrl_estop_i,
  input  wire alarm_i,
  input  wire ext_estop_n_i,
  output reg  base_on_o,
  output reg  dyn_brake_o,
  output reg  ctrl_es_wrn_o,
  output reg  local_es_wrn_o
);
  wire brake_stop;
  assign brake_stop = ctrl_estop_i | alarm_i | ~ext_estop_n_i;

  // stop decision, brake stops beat coasting
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      base_on_o      <= 1'b0;
      dyn_brake_o    <= 1'b0;
      ctrl_es_wrn_o  <= 1'b0;
      local_es_wrn_o <= 1'b0;
    end else begin
      ctrl_es_wrn_o  <= ctrl_estop_i;
      local_es_wrn_o <= ~ext_estop_n_i;
      if (brake_stop) begin
        base_on_o   <= 1'b0;
        dyn_brake_o <= 1'b1;
      end else if (servo_off_cmd_i || !servo_on_i) begin
        base_on_o   <= 1'b0;
        dyn_brake_o <= 1'b0;
      end else begin
        base_on_o   <= 1'b1;
        dyn_brake_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/sdss_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sdss_chk (
  input wire logic       CLK_SYS_I,
  input wire logic       NRST_I,
  input wire logic       POWER_ON_I,
  input wire logic       CTRL_SERVO_OFF_I,
  input wire logic       CTRL_ESTOP_I,
  input wire logic       EXTERNAL_FORCED_STOP_INPUT_N_I,
  input wire logic       ALARM_I,
  input wire logic       SERVO_ON_O,
  input wire logic       ABS_LOST_ALARM_O,
  input wire logic       BASE_ON_O,
  input wire logic       DYN_BRAKE_O,
  input wire logic       CTRL_ES_WARN_O,
  input wire logic       LOCAL_ES_WARN_O,
  input wire logic [7:0] SEG0_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  // drive running with no stop cause present
  sequence s_run;
    SERVO_ON_O && !CTRL_SERVO_OFF_I && !CTRL_ESTOP_I && !ALARM_I
      && EXTERNAL_FORCED_STOP_INPUT_N_I;
  endsequence
  // servo-off held with every brake cause absent
  sequence s_coast;
    CTRL_SERVO_OFF_I && !CTRL_ESTOP_I && !ALARM_I && EXTERNAL_FORCED_STOP_INPUT_N_I
      && !ABS_LOST_ALARM_O;
  endsequence
  a_abs_refuses: assert property (ABS_LOST_ALARM_O |=> !SERVO_ON_O)
    else $error("servo on while position lost alarm active");
  a_alarm_refuses: assert property (ALARM_I |=> !SERVO_ON_O)
    else $error("servo on while alarm active");
  a_run_base: assert property (s_run [*4] |-> BASE_ON_O && !DYN_BRAKE_O)
    else $error("base circuit not on during servo on");
  a_coast_free: assert property (s_coast [*4] |-> !BASE_ON_O && !DYN_BRAKE_O)
    else $error("servo off does not coast");
  a_ctrl_stop: assert property (CTRL_ESTOP_I [*3] |->
    DYN_BRAKE_O && CTRL_ES_WARN_O && !BASE_ON_O)
    else $error("controller forced stop not braking");
  a_alarm_stop: assert property (ALARM_I [*3] |-> DYN_BRAKE_O && !BASE_ON_O)
    else $error("alarm not braking");
  a_ext_stop: assert property (!EXTERNAL_FORCED_STOP_INPUT_N_I [*5] |->
    DYN_BRAKE_O && LOCAL_ES_WARN_O && !BASE_ON_O)
    else $error("external forced stop not braking");
  a_abs_stands: assert property ((ABS_LOST_ALARM_O && POWER_ON_I) [*3] |=>
    ABS_LOST_ALARM_O)
    else $error("position lost alarm cleared without power cycle");
  a_alarm_blank: assert property (ALARM_I [*3] |-> SEG0_O == 8'h00)
    else $error("left digit not blank during alarm");
endmodule
bind sdss_top sdss_chk sdss_chk_inst (
  .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .POWER_ON_I(POWER_ON_I),
  .CTRL_SERVO_OFF_I(CTRL_SERVO_OFF_I), .CTRL_ESTOP_I(CTRL_ESTOP_I),
  .EXTERNAL_FORCED_STOP_INPUT_N_I(EXTERNAL_FORCED_STOP_INPUT_N_I), .ALARM_I(ALARM_I),
  .SERVO_ON_O(SERVO_ON_O), .ABS_LOST_ALARM_O(ABS_LOST_ALARM_O), .BASE_ON_O(BASE_ON_O),
  .DYN_BRAKE_O(DYN_BRAKE_O), .CTRL_ES_WARN_O(CTRL_ES_WARN_O),
  .LOCAL_ES_WARN_O(LOCAL_ES_WARN_O), .SEG0_O(SEG0_O));
`default_nettype wire

// ### tb/sdss_ctrl_mdl.sv
`timescale 1ns/1ps
`default_nettype none
module sdss_ctrl_mdl (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       drive_pwr_i,
  input  wire logic [1:0] cmd_i,
  input  wire logic       home_i,
  input  wire logic       pos_i,
  output var  logic       son_o,
  output var  logic       soff_o,
  output var  logic       es_o,
  output var  logic       up_o
);
  logic homed_q;
  // 1 servo on, 2 servo off, 3 servo off with forced stop
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      son_o   <= 1'b0;
      soff_o  <= 1'b0;
      es_o    <= 1'b0;
      up_o    <= 1'b0;
      homed_q <= 1'b0;
    end else begin
      son_o   <= drive_pwr_i && cmd_i == 2'd1;
      soff_o  <= cmd_i[1];
      es_o    <= cmd_i == 2'd3;
      homed_q <= homed_q | home_i;
      up_o    <= pos_i && homed_q;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk, nrst, pwr, amode, aval, tmode, fault, ext_n, alm, wrn, we, home, pos, dn;
  logic       son, soff, es, up, ccw, cw, aten, srv, absl, base, dyb, ces, les;
  logic [1:0] cmd;
  logic [3:0] rot, ph, dir, atm;
  logic [7:0] anum, wnum, atr, atr_o, s0, s1, s2, prev;
  logic [4:0] g1t [0:7] = '{5'h0b, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h0a};
  int         miscompares, checks, n, k;
  sdss_top #(.FLICK_CYC(32'd4), .FAULT_CYC(32'd8)) sdss_top_inst (
    .CLK_SYS_I(clk), .NRST_I(nrst), .POWER_ON_I(pwr), .ABS_MODE_I(amode),
    .ABS_VALID_I(aval), .TEST_MODE_I(tmode), .ROTARY_AXIS_SELECTOR_I(rot),
    .INIT_PHASE_I(ph), .COMM_FAULT_I(fault), .CTRL_SERVO_ON_I(son),
    .CTRL_SERVO_OFF_I(soff), .CTRL_ESTOP_I(es), .EXTERNAL_FORCED_STOP_INPUT_N_I(ext_n),
    .ALARM_I(alm), .ALARM_NUM_I(anum), .WARN_I(wrn), .WARN_NUM_I(wnum), .PARAM_WE_I(we),
    .ROTATION_DIRECTION_PARAM_I(dir), .AUTO_TUNING_MODE_PARAM_I(atm),
    .AUTO_TUNING_RESPONSE_PARAM_I(atr), .ADDR_UP_I(up), .ADDR_DN_I(dn),
    .MOTOR_CCW_O(ccw), .MOTOR_CW_O(cw), .AUTO_TUNE_EN_O(aten), .AUTO_TUNE_RESP_O(atr_o),
    .SERVO_ON_O(srv), .ABS_LOST_ALARM_O(absl), .BASE_ON_O(base), .DYN_BRAKE_O(dyb),
    .CTRL_ES_WARN_O(ces), .LOCAL_ES_WARN_O(les), .SEG0_O(s0), .SEG1_O(s1), .SEG2_O(s2));
  sdss_ctrl_mdl sdss_ctrl_mdl_inst (
    .clk_i(clk), .nrst_i(nrst), .drive_pwr_i(pwr), .cmd_i(cmd), .home_i(home),
    .pos_i(pos), .son_o(son), .soff_o(soff), .es_o(es), .up_o(up));
  // seven segment pattern, bits g..a
  function automatic logic [6:0] sg(input logic [4:0] g);
    case (g)
      5'h00: sg = 7'h3f;  5'h01: sg = 7'h06;  5'h02: sg = 7'h5b;  5'h03: sg = 7'h4f;
      5'h04: sg = 7'h66;  5'h05: sg = 7'h6d;  5'h06: sg = 7'h7d;  5'h07: sg = 7'h07;
      5'h08: sg = 7'h7f;  5'h09: sg = 7'h6f;  5'h0a: sg = 7'h77;  5'h0b: sg = 7'h7c;
      5'h0c: sg = 7'h39;  5'h0d: sg = 7'h5e;  5'h0e: sg = 7'h79;  5'h0f: sg = 7'h71;
      5'h11: sg = 7'h76;
      default: sg = 7'h00;
    endcase
  endfunction
  // next letter of the fault rotation b, C, d
  function automatic logic [7:0] nx(input logic [7:0] p);
    if (p === {1'b0, sg(5'h0b)}) nx = {1'b0, sg(5'h0c)};
    else if (p === {1'b0, sg(5'h0c)}) nx = {1'b0, sg(5'h0d)};
    else nx = {1'b0, sg(5'h0b)};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic show(input logic [4:0] g0, g1, g2, input logic [2:0] dp);
    chk("seg0", s0, {dp[0], sg(g0)});
    chk("seg1", s1, {dp[1], sg(g1)});
    chk("seg2", s2, {dp[2], sg(g2)});
  endtask
  task automatic power(input logic v);
    pwr = v;
    cyc(6);
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // free running clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog well beyond the expected run
  initial begin
    #(25 * 4000);
    miscompares++;
    stop_test;
  end
  // main sequence
  initial begin
    {nrst, pwr, tmode, fault, alm, wrn, we, home, pos, dn} = '0;
    {amode, aval, ext_n} = 3'b101;
    {cmd, rot, ph, dir, anum, wnum} = '0;
    atm = 4'h1;
    atr = 8'h0c;
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    cyc(3);
    chk("tune en", aten, 8'h01);
    chk("tune resp", atr_o, 8'h0c);
    {we, dir, atm, atr} = {1'b1, 4'h1, 4'h0, 8'h05};
    cyc(1);
    we = 1'b0;
    {home, pos} = 2'b11;
    cyc(4);
    chk("resp staged", atr_o, 8'h0c);
    chk("ccw", {cw, ccw}, 8'h01);
    pos = 1'b0;
    $display("test parameters done");
    power(1'b1);
    cmd = 2'd1;
    cyc(4);
    chk("abs alarm", absl, 8'h01);
    chk("refused", srv, 8'h00);
    chk("brake", dyb, 8'h01);
    show(5'h10, 5'h02, 5'h05, 3'b000);
    chk("tune off", aten, 8'h00);
    chk("resp active", atr_o, 8'h05);
    pos = 1'b1;
    cyc(4);
    chk("cw", {cw, ccw}, 8'h02);
    {pos, dn} = 2'b01;
    cyc(4);
    chk("ccw down", {cw, ccw}, 8'h01);
    {pos, cmd, dn} = '0;
    power(1'b0);
    power(1'b1);
    chk("abs cleared", absl, 8'h00);
    $display("test power cycle done");
    for (k = 0; k < 8; k++) begin
      ph = k[3:0];
      cyc(4);
      show(5'h0a, g1t[k], 5'h10, (k == 1) ? 3'b010 : 3'b000);
    end
    ph = 4'h8;
    for (k = 0; k < 16; k += 5) begin
      rot = k[3:0];
      cyc(5);
      show(5'h0b, 5'((k + 1) / 10), 5'((k + 1) % 10), 3'b000);
    end
    {rot, tmode} = {4'h0, 1'b1};
    cyc(5);
    show(5'h0b, 5'h00, 5'h00, 3'b100);
    {ph, tmode} = {4'ha, 1'b0};
    cyc(5);
    show(5'h0c, 5'h00, 5'h01, 3'b000);
    $display("test display done");
    {ph, cmd} = {4'h9, 2'd1};
    cyc(5);
    chk("servo on", {srv, base, dyb}, 8'h06);
    show(5'h0d, 5'h00, 5'h01, 3'b000);
    {wrn, wnum} = {1'b1, 8'h92};
    cyc(4);
    chk("warn digit", s1 & 8'h7f, {1'b0, sg(5'h09)});
    chk("warn low", s2, {1'b0, sg(5'h02)});
    chk("warn blank", s0, 8'h00);
    n = 0;
    repeat (16) begin
      cyc(1);
      n += s1[7] ? 1 : 0;
    end
    chk("flicker", 8'(n), 8'h08);
    wrn = 1'b0;
    cmd = 2'd2;
    cyc(5);
    chk("coast", {base, dyb}, 8'h00);
    cmd = 2'd3;
    cyc(5);
    chk("ctrl stop", {base, dyb, ces}, 8'h03);
    cmd = 2'd1;
    cyc(5);
    ext_n = 1'b0;
    cyc(6);
    chk("ext stop", {base, dyb, les}, 8'h03);
    show(5'h10, 5'h0e, 5'h06, 3'b000);
    ext_n = 1'b1;
    cyc(6);
    chk("servo back", {srv, base}, 8'h03);
    {alm, anum} = {1'b1, 8'h16};
    cyc(5);
    chk("alarm stop", {srv, base, dyb}, 8'h01);
    show(5'h10, 5'h01, 5'h06, 3'b000);
    {alm, cmd, ph} = '0;
    $display("test stops done");
    fault = 1'b1;
    cyc(3);
    prev = s1;
    n = 0;
    repeat (60) begin
      cyc(1);
      if (s1 !== prev) begin
        chk("fault step", s1, nx(prev));
        prev = s1;
        n++;
      end
    end
    chk("fault steps", (n >= 5) ? 8'h01 : 8'h00, 8'h01);
    $display("test fault done");
    stop_test;
  end
endmodule
`default_nettype wire
